// file: src/timer_cont_counter.sv
// Timer with continuous and event-counter modes behind an APB slave
`timescale 1ns/1ps
`default_nettype none

module timer_cont_counter #(
    parameter int CNT_W = 32
) (
    input wire logic clk_sys, // 200 MHz system clock
    input wire logic arst_n, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, high for write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic pready, // APB ready
    output logic [31:0] prdata, // APB read data
    output logic pslverr, // APB error for unmapped address
    input wire logic tmr_in, // Timer pin input level
    output logic tmr_out, // Timer pin output level
    output logic tmr_out_n, // Complementary output level
    output logic tmr_oe, // Timer pin output enable
    output logic irq // Interrupt request, level
);

    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("CNT_W must lie between 2 and 32");
        end
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] cmp_ff;
    logic flag_ff;
    timer_pkg::ctrl0_type ctrl0_ff;
    timer_pkg::ctrl1_type ctrl1_ff;
    logic [15:0] pres_cnt_ff;
    logic sync_meta_ff;
    logic sync_ff;
    logic sync_last_ff;
    logic toggle_ff;

    // APB decode; writes land on the edge that completes the access
    logic access;
    logic wr_fire;
    logic addr_hit;
    logic wr_cnt;
    logic [31:0] nxt_prdata;

    assign access = psel & penable;
    assign wr_fire = access & pwrite & pready;
    assign wr_cnt = wr_fire && paddr == timer_pkg::CNT_OFS;

    always_comb begin
        addr_hit = 1'b1;
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            timer_pkg::CNT_OFS: nxt_prdata = 32'(cnt_ff);
            timer_pkg::CMP_OFS: nxt_prdata = 32'(cmp_ff);
            timer_pkg::FLAG_OFS: nxt_prdata[timer_pkg::FLAG_IRQ_BIT] = flag_ff;
            timer_pkg::CTRL0_OFS: begin
                nxt_prdata[timer_pkg::CTRL0_MODE_LSB +: 4] = ctrl0_ff.mode;
                nxt_prdata[timer_pkg::CTRL0_PRES_LSB +: 4] = ctrl0_ff.pres;
                nxt_prdata[timer_pkg::CTRL0_POL_BIT] = ctrl0_ff.pol;
                nxt_prdata[timer_pkg::CTRL0_EN_BIT] = ctrl0_ff.en;
            end
            timer_pkg::CTRL1_OFS: begin
                nxt_prdata[timer_pkg::CTRL1_IE_BIT] = ctrl1_ff.irq_en;
                nxt_prdata[timer_pkg::CTRL1_OUTEN_BIT] = ctrl1_ff.outen;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // One wait state so that every bus output comes from a flop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            prdata <= (access & ~pready & ~pwrite) ? nxt_prdata
                                                   : 32'h0000_0000;
            pslverr <= access & ~pready & ~addr_hit;
        end
    end

    // settings change on any write, whether the timer is on or off
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl0_ff <= timer_pkg::CTRL0_RESET;
            ctrl1_ff <= timer_pkg::CTRL1_RESET;
            cmp_ff <= CNT_W'(timer_pkg::CMP_RESET);
        end else if (wr_fire) begin
            unique case (paddr)
                timer_pkg::CTRL0_OFS: begin
                    ctrl0_ff.mode <= pwdata[timer_pkg::CTRL0_MODE_LSB +: 4];
                    ctrl0_ff.pres <= pwdata[timer_pkg::CTRL0_PRES_LSB +: 4];
                    ctrl0_ff.pol <= pwdata[timer_pkg::CTRL0_POL_BIT];
                    ctrl0_ff.en <= pwdata[timer_pkg::CTRL0_EN_BIT];
                end
                timer_pkg::CTRL1_OFS: begin
                    ctrl1_ff.irq_en <= pwdata[timer_pkg::CTRL1_IE_BIT];
                    ctrl1_ff.outen <= pwdata[timer_pkg::CTRL1_OUTEN_BIT];
                end
                timer_pkg::CMP_OFS: cmp_ff <= pwdata[CNT_W-1:0];
                default: ;
            endcase
        end
    end

    // Mode decode
    logic mode_cont;
    logic mode_ctr;
    logic match;

    assign mode_cont = ctrl0_ff.en && ctrl0_ff.mode == timer_pkg::MODE_CONT;
    assign mode_ctr = ctrl0_ff.en && ctrl0_ff.mode == timer_pkg::MODE_COUNTER;
    assign match = cnt_ff == cmp_ff;

    // Prescaler: timer clock is one tick every 2^pres system clocks
    logic [15:0] pres_lim;
    logic tick;

    assign pres_lim = 16'((17'h0_0001 << ctrl0_ff.pres) - 17'h0_0001);
    assign tick = mode_cont && pres_cnt_ff == pres_lim;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pres_cnt_ff <= timer_pkg::PRES_CNT_RESET;
        end else if (!mode_cont || tick) begin
            pres_cnt_ff <= timer_pkg::PRES_CNT_RESET;
        end else begin
            pres_cnt_ff <= pres_cnt_ff + 16'h0001;
        end
    end

    // two flops against metastability, third for edge history
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync_meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            sync_last_ff <= 1'b0;
        end else begin
            sync_meta_ff <= tmr_in;
            sync_ff <= sync_meta_ff;
            sync_last_ff <= sync_ff;
        end
    end

    // pol low counts rising edges, pol high counts falling edges
    logic in_edge;

    assign in_edge = ctrl0_ff.pol ? (sync_last_ff & ~sync_ff)
                                  : (sync_ff & ~sync_last_ff);

    // continuous period ends on the tick after the match tick
    // counter period ends on the clock after the match
    logic period_end;
    logic incr;

    assign period_end = match & ((mode_cont & tick) | mode_ctr);
    // counter mode steps on input edges, prescaler unused
    assign incr = ~match & ((mode_cont & tick) | (mode_ctr & in_edge));

    // written value starts period one; reloads use one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= CNT_W'(timer_pkg::CNT_RESET);
        end else if (wr_cnt) begin
            cnt_ff <= pwdata[CNT_W-1:0];
        end else if (period_end) begin
            cnt_ff <= CNT_W'(timer_pkg::CNT_RELOAD);
        end else if (incr) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end
    end

    // set beats a same-cycle write-one clear
    logic flag_clr;

    assign flag_clr = wr_fire && paddr == timer_pkg::FLAG_OFS
                      && pwdata[timer_pkg::FLAG_IRQ_BIT];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_ff <= 1'b0;
        end else if (period_end) begin
            flag_ff <= 1'b1;
        end else if (flag_clr) begin
            flag_ff <= 1'b0;
        end
    end

    // level stays high while flag set, so no second request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= flag_ff & ctrl1_ff.irq_en;
        end
    end

    // toggle; disable returns the pin to its idle level
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            toggle_ff <= 1'b0;
        end else if (!ctrl0_ff.en) begin
            toggle_ff <= 1'b0;
        end else if (period_end && ctrl1_ff.outen) begin
            toggle_ff <= ~toggle_ff;
        end
    end

    // pol is the idle level; complement drives the inverted pin
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tmr_out <= 1'b0;
            tmr_out_n <= 1'b1;
            tmr_oe <= 1'b0;
        end else begin
            tmr_out <= ctrl0_ff.pol ^ toggle_ff;
            tmr_out_n <= ~(ctrl0_ff.pol ^ toggle_ff);
            // Pin stays an input in counter mode
            tmr_oe <= ctrl1_ff.outen
                      && ctrl0_ff.mode != timer_pkg::MODE_COUNTER;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_cont_match_tick;
        mode_cont && tick && match && !wr_cnt;
    endsequence

    sequence s_reload_flag;
        cnt_ff == CNT_W'(timer_pkg::CNT_RELOAD) && flag_ff;
    endsequence

    a_cont_reload_flag: assert property (
        s_cont_match_tick |=> s_reload_flag)
        else $error("continuous match tick did not reload and flag");

    a_cont_tick_step: assert property (
        mode_cont && !wr_cnt && !match && !tick |=> $stable(cnt_ff))
        else $error("continuous count moved without a timer tick");

    a_ctr_edge_count: assert property (
        mode_ctr && !wr_cnt && !match && in_edge
        |=> cnt_ff == $past(cnt_ff) + CNT_W'(1))
        else $error("counter mode missed a qualifying edge");

    a_ctr_no_edge_hold: assert property (
        mode_ctr && !wr_cnt && !match && !in_edge |=> $stable(cnt_ff))
        else $error("counter mode counted without an edge");

    a_ctr_period_end: assert property (
        mode_ctr && match && !wr_cnt |=> s_reload_flag ##0 ctrl0_ff.en)
        else $error("counter period end did not reload, flag, stay on");

    a_out_toggle: assert property (
        period_end && ctrl1_ff.outen && !wr_fire
        |-> ##2 tmr_out != $past(tmr_out))
        else $error("output did not invert at period end");

    a_flag_set_wins: assert property (
        period_end |=> flag_ff)
        else $error("flag lost at period end");

    a_irq_gate: assert property (
        !ctrl1_ff.irq_en |=> !irq)
        else $error("interrupt raised while disabled");

    a_idle_level: assert property (
        !ctrl0_ff.en && $past(!ctrl0_ff.en)
        |=> tmr_out == $past(ctrl0_ff.pol) && tmr_out_n == !tmr_out)
        else $error("idle output level or complement wrong");

    a_sync_chain: assert property (
        ##2 sync_ff == $past(tmr_in, 2))
        else $error("synchroniser depth wrong");

    a_cont_step: assert property (
        mode_cont && tick && !match && !wr_cnt
        |=> cnt_ff == $past(cnt_ff) + CNT_W'(1))
        else $error("continuous count missed a timer tick");

    a_tick_spacing: assert property (
        tick && ctrl0_ff.pres != 4'h0 && !wr_fire |=> !tick)
        else $error("prescaled tick came on two clocks in a row");

    a_pres_idle: assert property (
        !mode_cont |=> pres_cnt_ff == timer_pkg::PRES_CNT_RESET)
        else $error("prescaler ran outside continuous mode");

    a_period_stays_on: assert property (
        period_end && !(wr_fire && paddr == timer_pkg::CTRL0_OFS)
        |=> ctrl0_ff.en)
        else $error("timer disabled itself at period end");

    a_cnt_write: assert property (
        wr_cnt |=> cnt_ff == $past(pwdata[CNT_W-1:0]))
        else $error("written count value not loaded");

    a_ctr_wrong_edge: assert property (
        mode_ctr && !match && !wr_cnt
        && (ctrl0_ff.pol ? $rose(sync_ff) : $fell(sync_ff))
        |=> $stable(cnt_ff))
        else $error("counter mode counted the other edge");

    a_flag_sticky: assert property (
        flag_ff && !flag_clr |=> flag_ff)
        else $error("flag dropped without a write-one clear");

    a_flag_w1c: assert property (
        flag_clr && !period_end |=> !flag_ff)
        else $error("write-one did not clear the flag");

    a_irq_follow: assert property (
        flag_ff && ctrl1_ff.irq_en |=> irq)
        else $error("enabled flag did not raise the request");

    a_out_held: assert property (
        period_end && !ctrl1_ff.outen && !wr_fire |-> ##2 $stable(tmr_out))
        else $error("output moved although output disabled");

    a_out_complement: assert property (
        tmr_out_n != tmr_out)
        else $error("complementary output not inverted");

    a_ctr_pin_input: assert property (
        ctrl0_ff.mode == timer_pkg::MODE_COUNTER |=> !tmr_oe)
        else $error("pin driven in counter mode");

    // Bus handshake shape
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready stood longer than one clock");

    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("error shown without ready");

endmodule : timer_cont_counter

`default_nettype wire

// file: src/timer_pkg.sv
// Constants, field layouts and carrier types for the continuous/event timer
// What this block does
// - Continuous mode counts to compare, reloads one
// - End-of-period actions on following timer clock
// - Output enabled: invert output every period end
// - Continuous period end sets interrupt flag
// - Written count affects first period only
// - First period compare-initial+1, later compare clocks
// - Mode 1 continuous, mode 2 event counter
// - Counter mode counts input transitions only
// - Polarity picks rising or falling edge only
// - Counter mode ignores prescaler, samples directly
// - Counter period end reloads, flags, stays enabled
// - Counter mode toggles output only when enabled
// - Flag write-one-to-clear, no repeated interrupt
// - Readable count equals start value plus transitions this period
// - Interrupt forwarded only when enable set
// - Polarity sets idle level; complementary output
package timer_pkg;

    localparam logic [7:0] CNT_OFS = 8'h00;
    localparam logic [7:0] CMP_OFS = 8'h04;
    localparam logic [7:0] FLAG_OFS = 8'h08;
    localparam logic [7:0] CTRL0_OFS = 8'h0C;
    localparam logic [7:0] CTRL1_OFS = 8'h10;

    localparam int CTRL0_MODE_LSB = 0;
    localparam int CTRL0_PRES_LSB = 4;
    localparam int CTRL0_POL_BIT = 8;
    localparam int CTRL0_EN_BIT = 15;
    localparam int CTRL1_IE_BIT = 0;
    localparam int CTRL1_OUTEN_BIT = 1;
    localparam int FLAG_IRQ_BIT = 0;

    localparam logic [3:0] MODE_CONT = 4'h1;
    localparam logic [3:0] MODE_COUNTER = 4'h2;

    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_RELOAD = 32'h0000_0001;
    localparam logic [31:0] CMP_RESET = 32'hFFFF_FFFF;
    localparam logic [15:0] PRES_CNT_RESET = 16'h0000;

    typedef struct packed {
        logic en;
        logic pol;
        logic [3:0] pres;
        logic [3:0] mode;
    } ctrl0_type;

    typedef struct packed {
        logic outen;
        logic irq_en;
    } ctrl1_type;

    localparam ctrl0_type CTRL0_RESET = '{en: 1'b0, pol: 1'b0,
        pres: 4'h0, mode: 4'h0};
    localparam ctrl1_type CTRL1_RESET = '{outen: 1'b0, irq_en: 1'b0};

endpackage : timer_pkg

// file: sim/pin_source.sv
// Model of the external source on the timer input pin
`timescale 1ns/1ps
`default_nettype none

module pin_source (
    input wire logic clk_sys, // Clock used to pace the pin levels
    output logic tmr_in // Level driven onto the timer input
);
    initial tmr_in = 1'b0;

    task automatic pulses(input logic idle, input int n);
        tmr_in <= idle;
        repeat (6) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            tmr_in <= ~idle;
            repeat (5) @(posedge clk_sys);
            tmr_in <= idle;
            repeat (5) @(posedge clk_sys);
        end
    endtask : pulses
endmodule : pin_source
`default_nettype wire

// file: sim/test_timer_cont_counter.sv
// Self-checking bench for the continuous/event timer
`timescale 1ns/1ps
`default_nettype none

module test_timer_cont_counter;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready, pslverr, tmr_in, tmr_out, tmr_out_n, tmr_oe, irq;
    logic [31:0] prdata, rdat, seed, cmp;
    logic rerr;
    logic [3:0] pres;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;

    timer_cont_counter u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out),
        .tmr_out_n(tmr_out_n), .tmr_oe(tmr_oe), .irq(irq));
    pin_source u_pin (.clk_sys(clk_sys), .tmr_in(tmr_in));

    always #2.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [31:0] c0(input logic en, input logic pol,
        input logic [3:0] pr, input logic [3:0] mode);
        return {16'h0000, en, 6'h00, pol, pr, mode};
    endfunction : c0

    // Later periods last the compare value in timer ticks
    function automatic int period(input logic [31:0] c, input logic [3:0] p);
        return int'(c) << p;
    endfunction : period

    task automatic conclude;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Held until pready seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the bench timeout ends a wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge clk_sys);
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, exp);
    endtask : rchk

    // Bounded wait for the next output edge
    task automatic wait_toggle(output int k);
        logic o;
        o = tmr_out;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (tmr_out === o && k < 2000);
    endtask : wait_toggle

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        seed = 32'h4a5f;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rchk(timer_pkg::CNT_OFS, 32'h0000_0000);
        rchk(timer_pkg::CMP_OFS, 32'hFFFF_FFFF);
        rchk(timer_pkg::FLAG_OFS, 32'h0000_0000);
        rchk(timer_pkg::CTRL0_OFS, 32'h0000_0000);
        rchk(timer_pkg::CTRL1_OFS, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        chk(rerr, 1'b1);
        chk(rdat, 32'h0000_0000);
        // Continuous run with a random start value and prescaler
        seed = lfsr(lfsr(seed));
        cmp = 32'h0000_0004 + seed[2:0];
        pres = {3'b000, seed[8]};
        apb(1'b1, timer_pkg::CTRL1_OFS, 32'h0000_0002);
        apb(1'b1, timer_pkg::CMP_OFS, cmp);
        apb(1'b1, timer_pkg::CNT_OFS, {30'h0, seed[4:3]});
        apb(1'b1, timer_pkg::CTRL0_OFS, c0(1'b1, seed[9], pres, 4'h1));
        wait_toggle(n);
        wait_toggle(n);
        chk(n, period(cmp, pres));
        wait_toggle(n);
        chk(n, period(cmp, pres));
        chk(tmr_out_n, {31'h0000_0000, ~tmr_out});
        chk(tmr_oe, 1'b1);
        chk(irq, 1'b0);
        rchk(timer_pkg::FLAG_OFS, 32'h0000_0001);
        apb(1'b1, timer_pkg::CTRL1_OFS, 32'h0000_0003);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1'b1);
        apb(1'b1, timer_pkg::CTRL0_OFS, c0(1'b0, seed[9], pres, 4'h1));
        apb(1'b1, timer_pkg::FLAG_OFS, 32'h0000_0001);
        rchk(timer_pkg::FLAG_OFS, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        chk(irq, 1'b0);
        chk(tmr_out, seed[9]);
        // Counter mode for both edge polarities; prescaler must not matter
        for (int p = 0; p < 2; p++) begin
            seed = lfsr(seed);
            cmp = 32'h0000_0003 + seed[1:0];
            apb(1'b1, timer_pkg::CTRL1_OFS, 32'h0000_0001);
            apb(1'b1, timer_pkg::FLAG_OFS, 32'h0000_0001);
            apb(1'b1, timer_pkg::CMP_OFS, cmp);
            apb(1'b1, timer_pkg::CNT_OFS, 32'h0000_0000);
            u_pin.pulses(p[0], 0);
            apb(1'b1, timer_pkg::CTRL0_OFS, c0(1'b1, p[0], seed[7:4], 4'h2));
            u_pin.pulses(p[0], int'(cmp) - 1);
            repeat (6) @(posedge clk_sys);
            rchk(timer_pkg::CNT_OFS, cmp - 1);
            rchk(timer_pkg::FLAG_OFS, 32'h0000_0000);
            u_pin.pulses(p[0], 1);
            repeat (6) @(posedge clk_sys);
            rchk(timer_pkg::CNT_OFS, 32'h0000_0001);
            rchk(timer_pkg::FLAG_OFS, 32'h0000_0001);
            chk(irq, 1'b1);
            chk(tmr_out, p[0]);
            chk(tmr_oe, 1'b0);
            apb(1'b1, timer_pkg::CTRL0_OFS, 32'h0000_0000);
        end
        conclude();
    end
endmodule : test_timer_cont_counter
`default_nettype wire
